// ### port_pin_drive_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module port_pin_drive_select_tb;
   import ppds_pkg::*;
   logic          i_clock = 1'h0;
   logic          i_resetn = 1'h0;
   ppds_bus_req_t bus = '0;
   logic [DW-1:0] rd_data;
   logic [7:0]    dir = 8'h00, dat = 8'h00, pad_in, level;
   logic [7:0]    dirs [4] = '{8'h00, 8'hFF, 8'hF0, 8'h0F};
   logic [7:0]    dats [3] = '{8'h00, 8'hFF, 8'h5A};
   ppds_pad_ctl_t pads, e, g;
   // Select pair written before the pad tests: pins 0 to 3 carry codes 00, 01, 10, 11
   localparam logic [7:0] HI_SEL = 8'hCC;
   localparam logic [7:0] LO_SEL = 8'hAA;
   // Floating pads wander, so level bits of unbiased pins are masked off a read
   logic [15:0]   rd_mask = 16'hFFFF;
   int            n_fail = 0, cmp_count = 0, cyc = 0;
   ppds_port_pin_drive_select dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_bus(bus),
      .o_rd_data(rd_data), .i_pin_direction(dir), .i_pin_data(dat), .i_pad_in(pad_in),
      .o_pads(pads), .o_pin_level(level));
   ppds_pad_model pm (.i_clock(i_clock), .i_pads(pads), .o_pad_in(pad_in));
   initial forever #20 i_clock = ~i_clock;
   function automatic ppds_pad_ctl_t exp_pads(input logic [7:0] dr, dt);
      ppds_pad_ctl_t p;
      logic [1:0]    c;
      p = '0;
      for (int n = 0; n < PINS; n++) begin
         c = {HI_SEL[n], LO_SEL[n]};
         if (dr[n] == DIR_OUTPUT) begin
            p.out[n] = (c == CODE_PCH_PDOWN) | ((c == CODE_CMOS_HIZ) & dt[n]);
            p.oe[n] = (c == CODE_CMOS_HIZ) | ((c == CODE_PCH_PDOWN) & dt[n])
                    | ((c == CODE_NCH_PUP) & ~dt[n]);
         end else begin
            p.pull_down[n] = (c == CODE_PCH_PDOWN);
            p.pull_up[n] = (c == CODE_NCH_PUP);
         end
      end
      return p;
   endfunction
   task automatic wr(input logic [15:0] a, d, input logic w);
      @(posedge i_clock) bus <= '{addr: a, wr_data: d, wr: 1'h1, rd: 1'h0, word: w};
      @(posedge i_clock) bus <= '0;
   endtask
   task automatic rd(input logic [15:0] a, input logic w, input logic [15:0] x);
      @(posedge i_clock) bus <= '{addr: a, wr_data: 16'h0000, wr: 1'h0, rd: 1'h1, word: w};
      @(posedge i_clock) bus <= '0;
      #1 `CHK("rd_data", x, rd_data & rd_mask)
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         stop_test;
      end
   end
   initial begin
      repeat (5) @(posedge i_clock);
      i_resetn <= 1'h1;
      rd(ADDR_SEL_LOW, 1'h1, WORD_ZERO);
      wr(ADDR_SEL_LOW, 16'hCCAA, 1'h1);
      rd(ADDR_SEL_HIGH, 1'h0, 16'h00CC);
      rd(ADDR_SEL_LOW, 1'h0, 16'h00AA);
      wr(ADDR_SEL_HIGH, 16'h0033, 1'h0);
      rd(ADDR_SEL_LOW, 1'h1, 16'h33AA);
      wr(ADDR_SEL_HIGH, 16'h00CC, 1'h0);
      wr(16'hF224, 16'hFFFF, 1'h1);
      rd(16'hF224, 1'h1, WORD_ZERO);
      rd(ADDR_SEL_HIGH, 1'h1, WORD_ZERO);
      wr(ADDR_ACTIVE, 16'h00FF, 1'h0);
      rd(ADDR_SEL_LOW, 1'h1, 16'hCCAA);
      $display("test registers done");
      for (int i = 0; i < 12; i++) begin
         @(posedge i_clock) dir <= dirs[i % 4];
         dat <= dats[i / 4];
         repeat (6) @(posedge i_clock);
         #1 e = exp_pads(dir, dat);
         e.out = e.out & e.oe;
         g = pads;
         g.out = g.out & g.oe;
         `CHK("pads", e, g)
         `CHK("level", e.out | e.pull_up, level & (e.oe | e.pull_up | e.pull_down))
         rd(ADDR_ACTIVE, 1'h0, {8'h00, e.oe});
         rd_mask = {8'hFF, e.oe | e.pull_up | e.pull_down};
         rd(ADDR_LEVEL, 1'h1, {e.oe, e.out | e.pull_up});
         rd_mask = 16'hFFFF;
      end
      $display("test pads done");
      @(posedge i_clock) i_resetn <= 1'h0;
      repeat (2) @(posedge i_clock);
      i_resetn <= 1'h1;
      #1 `CHK("reset pads", 32'h0, pads)
      `CHK("reset level", BYTE_ZERO, level)
      rd(ADDR_SEL_LOW, 1'h1, WORD_ZERO);
      $display("test reset done");
      stop_test;
   end
endmodule
`default_nettype wire

// ### ppds_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ppds_checker (
   input wire logic                      i_clock,
   input wire logic                      i_resetn,
   input wire ppds_pkg::ppds_bus_req_t   i_bus,
   input wire logic [ppds_pkg::DW-1:0]   o_rd_data,
   input wire logic [ppds_pkg::PINS-1:0] i_pin_direction,
   input wire logic [ppds_pkg::PINS-1:0] i_pin_data,
   input wire logic [ppds_pkg::PINS-1:0] i_pad_in,
   input wire ppds_pkg::ppds_pad_ctl_t   o_pads,
   input wire logic [ppds_pkg::PINS-1:0] o_pin_level
);
   import ppds_pkg::*;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   sequence odd_word_rd;
      i_bus.rd && i_bus.word && i_bus.addr[0];
   endsequence
   sequence byte_rd;
      i_bus.rd && !i_bus.word;
   endsequence
   chk_rd_quiet: assert property (!$past(i_bus.rd) |-> o_rd_data == 16'h0000)
      else $error("read data not zero outside a read");
   chk_odd_word: assert property (odd_word_rd |=> o_rd_data == 16'h0000)
      else $error("odd word read returned data");
   chk_byte_upper: assert property (byte_rd |=> o_rd_data[15:8] == 8'h00)
      else $error("byte read upper half not zero");
   chk_reset_clear: assert property (disable iff (1'h0) !i_resetn |=>
      o_pads == 32'h0 && o_rd_data == 16'h0000 && o_pin_level == 8'h00)
      else $error("outputs not cleared by reset");
   chk_input_undriven: assert property ((o_pads.oe & $past(i_pin_direction)) == 8'h00)
      else $error("input pin driven");
   chk_pull_output: assert property (((o_pads.pull_up | o_pads.pull_down)
      & ~$past(i_pin_direction)) == 8'h00) else $error("pull on output pin");
   chk_pull_excl: assert property ((o_pads.pull_up & o_pads.pull_down) == 8'h00)
      else $error("both pulls on one pin");
   chk_drive_data: assert property ((o_pads.oe & (o_pads.out ^ $past(i_pin_data)))
      == 8'h00) else $error("driven level differs from data bit");
   chk_level_sync: assert property ($past(i_resetn) && $past(i_resetn, 2)
      && $past(i_resetn, 3) && $past(i_resetn, 4) |-> ((o_pin_level ^ i_pad_in)
      & (i_pad_in ~^ $past(i_pad_in)) & (i_pad_in ~^ $past(i_pad_in, 2))
      & (i_pad_in ~^ $past(i_pad_in, 3)) & (i_pad_in ~^ $past(i_pad_in, 4))) == 8'h00)
      else $error("steady pad level not reported");
endmodule
bind ppds_port_pin_drive_select ppds_checker u_chk (.i_clock, .i_resetn, .i_bus, .o_rd_data,
   .i_pin_direction, .i_pin_data, .i_pad_in, .o_pads, .o_pin_level);
`default_nettype wire

// ### ppds_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppds_pad_model (
   input  wire logic                    i_clock,
   input  wire ppds_pkg::ppds_pad_ctl_t i_pads,
   output logic [ppds_pkg::PINS-1:0]    o_pad_in
);
   import ppds_pkg::*;
   logic tog_ff = 1'h0;
   always_ff @(posedge i_clock) tog_ff <= ~tog_ff;
   // Undriven, unbiased pads wander every cycle
   always_comb begin
      for (int n = 0; n < PINS; n++) begin
         o_pad_in[n] = i_pads.oe[n] ? i_pads.out[n] : i_pads.pull_up[n] ? 1'h1
                     : i_pads.pull_down[n] ? 1'h0 : tog_ff;
      end
   end
endmodule
`default_nettype wire

// ### ppds_pkg.sv
package ppds_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int PINS = 8;
   localparam int AW   = 16;
   localparam int DW   = 16;
   localparam int BW   = 8;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [AW-1:0] ADDR_SEL_LOW  = 16'hF222;
   localparam logic [AW-1:0] ADDR_SEL_HIGH = 16'hF223;
   localparam logic [AW-1:0] ADDR_LEVEL    = 16'hF230;
   localparam logic [AW-1:0] ADDR_ACTIVE   = 16'hF231;

   localparam logic [BW-1:0] SEL_RESET     = 8'h00;
   localparam logic [BW-1:0] BYTE_ZERO     = 8'h00;
   localparam logic [DW-1:0] WORD_ZERO     = 16'h0000;

   // ------------------------------------------------------------
   // Codes and directions
   // ------------------------------------------------------------
   localparam logic [1:0] CODE_HIZ       = 2'h0;
   localparam logic [1:0] CODE_PCH_PDOWN = 2'h1;
   localparam logic [1:0] CODE_NCH_PUP   = 2'h2;
   localparam logic [1:0] CODE_CMOS_HIZ  = 2'h3;
   localparam logic       DIR_OUTPUT     = 1'b0;
   localparam logic       DIR_INPUT      = 1'b1;

   typedef enum logic [6:0] {
      MODE_OUT_HIZ  = 7'h01,
      MODE_OUT_PCH  = 7'h02,
      MODE_OUT_NCH  = 7'h04,
      MODE_OUT_CMOS = 7'h08,
      MODE_IN_HIZ   = 7'h10,
      MODE_IN_PDOWN = 7'h20,
      MODE_IN_PUP   = 7'h40
   } ppds_mode_t;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wr_data;
      logic          wr;
      logic          rd;
      logic          word;
   } ppds_bus_req_t;

   typedef struct packed {
      logic [PINS-1:0] out;
      logic [PINS-1:0] oe;
      logic [PINS-1:0] pull_up;
      logic [PINS-1:0] pull_down;
   } ppds_pad_ctl_t;

   typedef struct packed {
      logic [BW-1:0]   sel_low;
      logic [BW-1:0]   sel_high;
      logic [DW-1:0]   rd_data;
      ppds_pad_ctl_t   pads;
      logic [PINS-1:0] sync1;
      logic [PINS-1:0] sync2;
      logic [PINS-1:0] sync3;
      logic [PINS-1:0] level;
   } ppds_state_t;

   localparam ppds_state_t STATE_RESET = '{
      sel_low:   SEL_RESET,
      sel_high:  SEL_RESET,
      rd_data:   WORD_ZERO,
      pads:      '{out: BYTE_ZERO, oe: BYTE_ZERO, pull_up: BYTE_ZERO, pull_down: BYTE_ZERO},
      sync1:     BYTE_ZERO,
      sync2:     BYTE_ZERO,
      sync3:     BYTE_ZERO,
      level:     BYTE_ZERO
   };

endpackage

// ### ppds_port_pin_drive_select.sv
// Behaviour
// - The select register pair sits at the low select address and takes byte or word accesses.
// - Each pin's two-bit code is high-register bit n over low-register bit n.
// - A direction bit of 0 gives the code its output meaning, 1 its input meaning.
// - In output mode 00 floats, 01 is P-channel open drain, 10 N-channel open drain, 11 CMOS.
// - In input mode 00 and 11 float, 01 pulls down and 10 pulls up.
// - Reset clears both select registers, leaving every pin floating, whether its direction bit makes it an output or an input.
// - Input pins and output pins draw on separate sets of pad states.
// - The high select register sits one byte above the low one, and a word covers both.
// - Output pins with code 11 drive the data bit, 01 only a 1, 10 only a 0, 00 never; input pins report their sampled level back.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module ppds_port_pin_drive_select (
   input  wire logic                    i_clock,
   input  wire logic                    i_resetn,
   input  wire ppds_pkg::ppds_bus_req_t i_bus,
   output logic [ppds_pkg::DW-1:0]      o_rd_data,
   input  wire logic [ppds_pkg::PINS-1:0] i_pin_direction,
   input  wire logic [ppds_pkg::PINS-1:0] i_pin_data,
   input  wire logic [ppds_pkg::PINS-1:0] i_pad_in,
   output ppds_pkg::ppds_pad_ctl_t      o_pads,
   output logic [ppds_pkg::PINS-1:0]    o_pin_level
);
   import ppds_pkg::*;

   // ------------------------------------------------------------
   // Code decode
   // ------------------------------------------------------------
   function automatic ppds_mode_t decode_mode(input logic dir, input logic [1:0] code);
      ppds_mode_t m;
      m = MODE_OUT_HIZ;
      if (dir == DIR_OUTPUT) begin
         case (code)
            CODE_HIZ:       m = MODE_OUT_HIZ;
            CODE_PCH_PDOWN: m = MODE_OUT_PCH;
            CODE_NCH_PUP:   m = MODE_OUT_NCH;
            CODE_CMOS_HIZ:  m = MODE_OUT_CMOS;
            default:        m = MODE_OUT_HIZ;
         endcase
      end else begin
         case (code)
            CODE_HIZ:       m = MODE_IN_HIZ;
            CODE_PCH_PDOWN: m = MODE_IN_PDOWN;
            CODE_NCH_PUP:   m = MODE_IN_PUP;
            CODE_CMOS_HIZ:  m = MODE_IN_HIZ;
            default:        m = MODE_IN_HIZ;
         endcase
      end
      return m;
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   ppds_state_t state_ff;
   ppds_state_t nxt_state;

   logic        hit_low;
   logic        hit_high;
   logic        hit_level;
   logic        hit_active;
   logic [1:0]  code;
   ppds_mode_t  mode;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   // A word access must use the even address of a pair; odd word accesses are ignored.
   always_comb begin
      hit_low    = 1'b0;
      hit_high   = 1'b0;
      hit_level  = 1'b0;
      hit_active = 1'b0;
      if (i_bus.word) begin
         if (i_bus.addr == ADDR_SEL_LOW) begin
            hit_low  = 1'b1;
            hit_high = 1'b1;
         end
         if (i_bus.addr == ADDR_LEVEL) begin
            hit_level  = 1'b1;
            hit_active = 1'b1;
         end
      end else begin
         hit_low    = (i_bus.addr == ADDR_SEL_LOW);
         hit_high   = (i_bus.addr == ADDR_SEL_HIGH);
         hit_level  = (i_bus.addr == ADDR_LEVEL);
         hit_active = (i_bus.addr == ADDR_ACTIVE);
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      code      = CODE_HIZ;
      mode      = MODE_OUT_HIZ;

      // Register writes
      if (i_bus.wr) begin
         if (i_bus.word) begin
            if (hit_low) begin
               nxt_state.sel_low  = i_bus.wr_data[BW-1:0];
               nxt_state.sel_high = i_bus.wr_data[DW-1:BW];
            end
         end else begin
            if (hit_low) begin
               nxt_state.sel_low = i_bus.wr_data[BW-1:0];
            end
            if (hit_high) begin
               nxt_state.sel_high = i_bus.wr_data[BW-1:0];
            end
         end
      end

      // Register reads; data stand only in the cycle after the strobe
      nxt_state.rd_data = WORD_ZERO;
      if (i_bus.rd) begin
         if (i_bus.word) begin
            if (hit_low) begin
               nxt_state.rd_data = {state_ff.sel_high, state_ff.sel_low};
            end else if (hit_level) begin
               nxt_state.rd_data = {state_ff.pads.oe, state_ff.level};
            end
         end else begin
            if (hit_low) begin
               nxt_state.rd_data = {BYTE_ZERO, state_ff.sel_low};
            end else if (hit_high) begin
               nxt_state.rd_data = {BYTE_ZERO, state_ff.sel_high};
            end else if (hit_level) begin
               nxt_state.rd_data = {BYTE_ZERO, state_ff.level};
            end else if (hit_active) begin
               nxt_state.rd_data = {BYTE_ZERO, state_ff.pads.oe};
            end
         end
      end

      // Pad input sampling: third stage must agree with second before a change counts
      nxt_state.sync1 = i_pad_in;
      nxt_state.sync2 = state_ff.sync1;
      nxt_state.sync3 = state_ff.sync2;
      for (int n = 0; n < PINS; n++) begin
         if (state_ff.sync2[n] == state_ff.sync3[n]) begin
            nxt_state.level[n] = state_ff.sync3[n];
         end
      end

      // Pad control per pin
      for (int n = 0; n < PINS; n++) begin
         code = {state_ff.sel_high[n], state_ff.sel_low[n]};
         mode = decode_mode(i_pin_direction[n], code);
         nxt_state.pads.out[n]       = 1'b0;
         nxt_state.pads.oe[n]        = 1'b0;
         nxt_state.pads.pull_up[n]   = 1'b0;
         nxt_state.pads.pull_down[n] = 1'b0;
         case (mode)
            MODE_OUT_HIZ: begin
               nxt_state.pads.oe[n] = 1'b0;
            end
            MODE_OUT_PCH: begin
               nxt_state.pads.out[n] = 1'b1;
               nxt_state.pads.oe[n]  = i_pin_data[n];
            end
            MODE_OUT_NCH: begin
               nxt_state.pads.out[n] = 1'b0;
               nxt_state.pads.oe[n]  = ~i_pin_data[n];
            end
            MODE_OUT_CMOS: begin
               nxt_state.pads.out[n] = i_pin_data[n];
               nxt_state.pads.oe[n]  = 1'b1;
            end
            MODE_IN_PDOWN: begin
               nxt_state.pads.pull_down[n] = 1'b1;
            end
            MODE_IN_PUP: begin
               nxt_state.pads.pull_up[n] = 1'b1;
            end
            MODE_IN_HIZ: begin
               nxt_state.pads.oe[n] = 1'b0;
            end
            default: begin
               nxt_state.pads.oe[n] = 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         state_ff <= STATE_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign o_rd_data   = state_ff.rd_data;
   assign o_pads      = state_ff.pads;
   assign o_pin_level = state_ff.level;

endmodule

`default_nettype wire
